//--- src/periph_bus_regs.svh
// offsets, field positions, reset values and address decode bits for the peripheral bus block
// assumes inclusion by bare name from the design module and the bench
`ifndef PERIPH_BUS_REGS_SVH
`define PERIPH_BUS_REGS_SVH

// ----------------------------------------------------------------
// apb configuration map (byte addresses)
// ----------------------------------------------------------------
`define STRAP_CFG_OFFSET 12'h000
`define BUS_STATUS_OFFSET 12'h004
`define ADDR_STRAP_LSB 0
`define ADDR_STRAP_MSB 9
`define VEC_STRAP_LSB 16
`define VEC_STRAP_MSB 20
`define ADDR_STRAP_RESET 10'h000
`define VEC_STRAP_RESET 5'h17

// ----------------------------------------------------------------
// control_status_word fields
// ----------------------------------------------------------------
`define CSW_FAULT_BIT 15
`define CSW_FAULT_PERMIT_BIT 14
`define CSW_BUSY_BIT 11
`define CSW_FINISH_BIT 7
`define CSW_FINISH_PERMIT_BIT 6
`define CSW_WRITE_MASK 16'h4040

// ----------------------------------------------------------------
// bus address decode
// ----------------------------------------------------------------
`define PAGE_MSB 17
`define PAGE_LSB 13
`define STRAP_ADDR_MSB 12
`define STRAP_ADDR_LSB 3

`endif

//--- src/periph_bus_pkg.sv
// types shared by the peripheral bus slave and interrupt block
// assumes the offsets and fields come from periph_bus_regs.svh
package periph_bus_pkg;

  // bus cycle type on the two cycle-type lines
  typedef enum logic [1:0] {
    CYC_IN = 2'h0,
    CYC_IN_PAUSE = 2'h1,
    CYC_OUT = 2'h2,
    CYC_OUT_BYTE = 2'h3
  } cycle_t;

  typedef enum logic [1:0] {
    SLV_IDLE,
    SLV_ACTIVE,
    SLV_RELEASE
  } slave_state_t;

  typedef enum logic [1:0] {
    MST_IDLE,
    MST_REQUEST,
    MST_OWNER
  } master_state_t;

endpackage

//--- src/periph_bus_slave.sv
// peripheral-side bus slave: address selector, four device registers,
// two daisy-chained master circuits and an interrupt vector circuit
// assumes all bus inputs are already synchronous to pclk and active high
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`include "periph_bus_regs.svh"

// Behaviour
// (RULE_01) device registers occupy decoded bus addresses
// (RULE_02) all exchange goes through readable writable registers; here the data word and the csw permit bits are both, input is read-only, command is write-only
// (RULE_03) finish busy fault flags are read-only
// (RULE_04) write-only register reads back as zero
// (RULE_05) decode uses full 18-bit bus address
// (RULE_06) bit 0 byte select, bits 2:1 pick register
// (RULE_07) straps compare bits 12:3, fitted means zero
// (RULE_08) select only when bits 17:13 all ones
// (RULE_09) exactly one of four selects on match
// (RULE_10) take cycle type and msync, drive ssync
// (RULE_11) byte write gates and read gate by cycle
// (RULE_12) request when service wanted and permitted
// (RULE_13) grant plus free bus gives ownership
// (RULE_14) master circuit also usable for dma request
// (RULE_15) two masters plus vector circuit drive interrupt
// (RULE_16) vector bits 7:3 straps, bit 2 select
// (RULE_17) ssync answer gives vector accepted pulse
// (RULE_18) fault finish from bits 15 7, gated
// (RULE_19) both on level 4, fault sees grant first
// (RULE_20) either owner starts interrupt, bit 2 identifies
// (RULE_21) vector accepted clears the owning master
// (RULE_22) fault vector 104, finish vector 100 octal
// (RULE_23) ssync after msync, released after msync drops
module periph_bus_slave #(
  parameter int REQ_LEVEL = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [17:0] bus_addr,
  input wire logic [1:0] bus_cycle,
  input wire logic bus_msync,
  input wire logic bus_ssync_in,
  input wire logic [15:0] bus_data_in,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe_n,
  output logic bus_ssync_out,
  output logic bus_ssync_oe_n,
  input wire logic bus_grant_in,
  output logic bus_grant_out,
  input wire logic bus_free,
  output logic bus_request,
  output logic [2:0] bus_request_level,
  output logic bus_intr,
  output logic [1:0] bus_owner,
  output logic vector_accepted,
  output logic [3:0] reg_select,
  output logic out_high,
  output logic out_low,
  output logic in_gate,
  input wire logic fault_flag,
  input wire logic finish_flag,
  input wire logic busy_flag,
  input wire logic [15:0] device_data_in,
  output logic [15:0] data_word,
  output logic [15:0] command_word
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [9:0] addr_strap_reg;
  logic [4:0] vec_strap_reg;
  logic [15:0] csw_permit_reg;
  logic [15:0] csw_view;
  logic [15:0] read_word;
  logic addr_match;
  logic [3:0] sel_next;
  periph_bus_pkg::slave_state_t slv_state_reg;
  periph_bus_pkg::cycle_t cyc;
  logic wr_hi_next;
  logic wr_lo_next;
  logic rd_next;
  periph_bus_pkg::master_state_t mst_state_reg [2];
  logic [1:0] want;
  logic [1:0] pend_reg;
  logic [1:0] cond_prev_reg;
  logic [1:0] grant_chain;
  logic [1:0] req_now;
  logic [1:0] owner;
  logic ssync_in_prev_reg;
  logic accept_pulse;

  // one-hot register select from the two word-address bits
  function automatic logic [3:0] decode_select(input logic [1:0] idx);
    decode_select = 4'h1 << idx;
  endfunction

  // merges a bus write into a stored word under the byte gates
  function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] din,
                                              input logic hi, input logic lo);
    merge_bytes = {hi ? din[15:8] : old[15:8], lo ? din[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // address selector
  // ----------------------------------------------------------------
  always_comb
  begin
    cyc = periph_bus_pkg::cycle_t'(bus_cycle);
    // see RULE_05 see RULE_07 see RULE_08
    addr_match = (&bus_addr[`PAGE_MSB:`PAGE_LSB])
      && (bus_addr[`STRAP_ADDR_MSB:`STRAP_ADDR_LSB] == ~addr_strap_reg);
    sel_next = addr_match ? decode_select(bus_addr[2:1]) : 4'h0; // see RULE_06 see RULE_09
    // see RULE_11
    wr_hi_next = (cyc == periph_bus_pkg::CYC_OUT)
      || ((cyc == periph_bus_pkg::CYC_OUT_BYTE) && bus_addr[0]);
    wr_lo_next = (cyc == periph_bus_pkg::CYC_OUT)
      || ((cyc == periph_bus_pkg::CYC_OUT_BYTE) && !bus_addr[0]);
    rd_next = (cyc == periph_bus_pkg::CYC_IN) || (cyc == periph_bus_pkg::CYC_IN_PAUSE);
  end

  // flags come straight from device logic, so software cannot set them
  always_comb
  begin
    csw_view = csw_permit_reg;
    csw_view[`CSW_FAULT_BIT] = fault_flag; // see RULE_03
    csw_view[`CSW_FINISH_BIT] = finish_flag;
    csw_view[`CSW_BUSY_BIT] = busy_flag;
  end

  always_comb
  begin
    unique case (bus_addr[2:1])
      2'h0: read_word = csw_view;
      2'h1: read_word = data_word; // see RULE_02
      2'h2: read_word = device_data_in;
      2'h3: read_word = 16'h0000; // see RULE_04
    endcase
  end

  // ----------------------------------------------------------------
  // slave handshake
  // ----------------------------------------------------------------
  // active waits for msync to drop before leaving, so a held strobe is served once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slv_state_reg <= periph_bus_pkg::SLV_IDLE;
      reg_select <= 4'h0;
      out_high <= 1'b0;
      out_low <= 1'b0;
      in_gate <= 1'b0;
      bus_ssync_out <= 1'b0;
      bus_ssync_oe_n <= 1'b1;
      bus_data_out <= 16'h0000;
      bus_data_oe_n <= 1'b1;
    end
    else
    begin
      unique case (slv_state_reg)
        periph_bus_pkg::SLV_IDLE:
        begin
          if (bus_msync && addr_match)
          begin
            slv_state_reg <= periph_bus_pkg::SLV_ACTIVE;
            reg_select <= sel_next; // see RULE_01
            out_high <= wr_hi_next;
            out_low <= wr_lo_next;
            in_gate <= rd_next;
            bus_ssync_out <= 1'b1; // see RULE_10 see RULE_23
            bus_ssync_oe_n <= 1'b0;
            bus_data_out <= rd_next ? read_word : 16'h0000;
            bus_data_oe_n <= !rd_next;
          end
        end
        periph_bus_pkg::SLV_ACTIVE:
        begin
          if (!bus_msync)
          begin
            slv_state_reg <= periph_bus_pkg::SLV_RELEASE;
            bus_ssync_out <= 1'b0; // see RULE_23
            bus_ssync_oe_n <= 1'b1;
            bus_data_oe_n <= 1'b1;
            bus_data_out <= 16'h0000;
            reg_select <= 4'h0;
            out_high <= 1'b0;
            out_low <= 1'b0;
            in_gate <= 1'b0;
          end
        end
        periph_bus_pkg::SLV_RELEASE:
        begin
          slv_state_reg <= periph_bus_pkg::SLV_IDLE;
        end
        default:
        begin
          slv_state_reg <= periph_bus_pkg::SLV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // device registers, written on the accepting edge
  // ----------------------------------------------------------------
  logic bus_write;
  assign bus_write = (slv_state_reg == periph_bus_pkg::SLV_IDLE) && bus_msync && addr_match
    && (wr_hi_next || wr_lo_next);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      csw_permit_reg <= 16'h0000;
      data_word <= 16'h0000;
      command_word <= 16'h0000;
    end
    else if (bus_write)
    begin
      unique case (bus_addr[2:1])
        2'h0: csw_permit_reg <= merge_bytes(csw_permit_reg, bus_data_in, wr_hi_next,
                                            wr_lo_next) & `CSW_WRITE_MASK; // see RULE_03
        2'h1: data_word <= merge_bytes(data_word, bus_data_in, wr_hi_next, wr_lo_next);
        2'h2: ; // input register ignores writes
        2'h3: command_word <= merge_bytes(command_word, bus_data_in, wr_hi_next, wr_lo_next);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources and master circuits
  // ----------------------------------------------------------------
  // index 0 is fault, index 1 is finish; a rising gated condition arms
  // a pending bit so a level that stays high asks only once
  logic [1:0] cond_now;
  assign cond_now = {finish_flag && csw_permit_reg[`CSW_FINISH_PERMIT_BIT],
                     fault_flag && csw_permit_reg[`CSW_FAULT_PERMIT_BIT]}; // see RULE_18

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_prev_reg <= 2'h0;
      pend_reg <= 2'h0;
    end
    else
    begin
      cond_prev_reg <= cond_now;
      // a fresh condition wins over the clear in the same cycle
      pend_reg <= (pend_reg & ~(owner & {2{accept_pulse}})) | (cond_now & ~cond_prev_reg);
    end
  end

  assign want = pend_reg & cond_now;
  // grant enters fault first, passes to finish when fault is not asking
  assign grant_chain = {bus_grant_in && !req_now[0], bus_grant_in}; // see RULE_19

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_master
      // generic master: the same logic serves a dma request line
      assign req_now[g] = (mst_state_reg[g] == periph_bus_pkg::MST_REQUEST); // see RULE_14
      assign owner[g] = (mst_state_reg[g] == periph_bus_pkg::MST_OWNER);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mst_state_reg[g] <= periph_bus_pkg::MST_IDLE;
        end
        else
        begin
          unique case (mst_state_reg[g])
            periph_bus_pkg::MST_IDLE:
            begin
              if (want[g])
              begin
                mst_state_reg[g] <= periph_bus_pkg::MST_REQUEST; // see RULE_12
              end
            end
            periph_bus_pkg::MST_REQUEST:
            begin
              if (!want[g])
              begin
                mst_state_reg[g] <= periph_bus_pkg::MST_IDLE;
              end
              else if (grant_chain[g] && bus_free && !owner[1 - g])
              begin
                mst_state_reg[g] <= periph_bus_pkg::MST_OWNER; // see RULE_13
              end
            end
            periph_bus_pkg::MST_OWNER:
            begin
              if (accept_pulse)
              begin
                mst_state_reg[g] <= periph_bus_pkg::MST_IDLE; // see RULE_21
              end
            end
            default:
            begin
              mst_state_reg[g] <= periph_bus_pkg::MST_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // vector circuit
  // ----------------------------------------------------------------
  assign accept_pulse = (|owner) && bus_ssync_in && !ssync_in_prev_reg; // see RULE_17

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ssync_in_prev_reg <= 1'b0;
      vector_accepted <= 1'b0;
      bus_intr <= 1'b0;
      bus_owner <= 2'h0;
      bus_request <= 1'b0;
      bus_request_level <= 3'h0;
      bus_grant_out <= 1'b0;
    end
    else
    begin
      ssync_in_prev_reg <= bus_ssync_in;
      vector_accepted <= accept_pulse;
      bus_intr <= (|owner) && !accept_pulse; // see RULE_15 see RULE_20
      bus_owner <= owner;
      bus_request <= |want && !(|owner);
      bus_request_level <= 3'(REQ_LEVEL); // see RULE_19
      bus_grant_out <= bus_grant_in && !(|req_now) && !(|owner);
    end
  end

  // interrupt vector is only read back in the apb status word, never driven onto the data lines
  logic [7:0] vector_value;
  // fitted strap forces zero; bit 2 names the fault master
  assign vector_value = {~vec_strap_reg, owner[0], 2'h0}; // see RULE_16 see RULE_22

  // ----------------------------------------------------------------
  // apb configuration slave, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      addr_strap_reg <= `ADDR_STRAP_RESET;
      vec_strap_reg <= `VEC_STRAP_RESET;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        unique case (paddr)
          `STRAP_CFG_OFFSET:
          begin
            prdata <= {11'h000, vec_strap_reg, 6'h00, addr_strap_reg};
          end
          `BUS_STATUS_OFFSET:
          begin
            prdata <= {vector_value, 2'h0, owner, 2'h0, req_now, csw_view};
          end
          default:
          begin
            pslverr <= 1'b1;
          end
        endcase
      end
      // write lands only on the edge that completes the transfer
      if (psel && penable && pready && pwrite && (paddr == `STRAP_CFG_OFFSET))
      begin
        addr_strap_reg <= pwdata[`ADDR_STRAP_MSB:`ADDR_STRAP_LSB];
        vec_strap_reg <= pwdata[`VEC_STRAP_MSB:`VEC_STRAP_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_select_onehot: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    (reg_select != 4'h0) |-> $onehot(reg_select))
    else $error("register select not one-hot");

  a_select_page: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_08
    $rose(bus_ssync_out) |-> $past(&bus_addr[17:13]))
    else $error("select outside peripheral page");

  a_ssync_answer: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_23
    (slv_state_reg == periph_bus_pkg::SLV_IDLE && bus_msync && addr_match) |=> bus_ssync_out)
    else $error("slave sync did not follow master sync");

  a_ssync_release: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_23
    (bus_ssync_out && !bus_msync) |=> !bus_ssync_out)
    else $error("slave sync held after master sync fell");

  a_byte_gates: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_11
    $rose(bus_ssync_out) |-> (out_high == ($past(bus_cycle) == 2'h2
      || ($past(bus_cycle) == 2'h3 && $past(bus_addr[0])))) && (in_gate == !$past(bus_cycle[1])))
    else $error("byte gate mismatch");

  a_wo_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    (in_gate && reg_select == 4'h8) |-> bus_data_out == 16'h0000)
    else $error("write-only register read nonzero");

  a_fault_first: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_19
    (req_now[0] && req_now[1] && bus_grant_in && bus_free && owner == 2'h0)
      |=> owner == 2'h1)
    else $error("finish won over fault");

  a_intr_vector: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_16
    owner[0] |-> vector_value[2] && vector_value[7:3] == ~vec_strap_reg)
    else $error("vector bits wrong");

  a_accept_clears: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_21
    accept_pulse |=> vector_accepted && owner == 2'h0 ##1 !bus_intr)
    else $error("ownership kept after vector accepted");

  a_intr_follows: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_20
    (|owner && !accept_pulse) |=> bus_intr)
    else $error("interrupt not raised for owner");

  a_flag_readonly: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_03
    1'b1 |-> csw_permit_reg[15] == 1'b0 && csw_permit_reg[7] == 1'b0)
    else $error("status flag stored from write");

  c_bus_write: cover property (@(posedge pclk) disable iff (!presetn)
    bus_write ##[1:4] !bus_ssync_out);
  c_fault_irq: cover property (@(posedge pclk) disable iff (!presetn)
    owner[0] ##[1:20] vector_accepted);
  c_finish_irq: cover property (@(posedge pclk) disable iff (!presetn)
    owner[1] ##[1:20] vector_accepted);
  c_apb_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

//--- tb/bus_processor_model.sv
// behavioural processor on the far side: grants any request without looking at its level and answers interrupts
// assumes the bench drives slave cycles itself and sets the answer delay
`timescale 1ns/10ps

module bus_processor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] ans_delay,
  input wire logic bus_request,
  input wire logic [1:0] bus_owner,
  input wire logic bus_intr,
  input wire logic vector_accepted,
  output logic bus_grant_in,
  output logic bus_free,
  output logic bus_ssync_in
);
  // ------------------------------------------------------------------
  // arbitration and interrupt answer
  // ------------------------------------------------------------------
  // a request withdrawn before ownership simply wastes the grant
  initial
  begin
    bus_grant_in = 1'b0;
    bus_free = 1'b0;
    bus_ssync_in = 1'b0;
  end

  always
  begin
    @(posedge pclk);
    if (presetn === 1'b1 && bus_request === 1'b1)
    begin
      repeat (ans_delay) @(posedge pclk);
      bus_grant_in <= 1'b1;
      bus_free <= 1'b1;
      for (int i = 0; i < 8 && bus_owner === 2'b00; i++)
        @(posedge pclk);
      bus_grant_in <= 1'b0;
      bus_free <= 1'b0;
      for (int i = 0; i < 8 && bus_intr !== 1'b1; i++)
        @(posedge pclk);
      if (bus_intr === 1'b1)
      begin
        repeat (ans_delay) @(posedge pclk);
        bus_ssync_in <= 1'b1;
        for (int i = 0; i < 40 && vector_accepted !== 1'b1; i++)
          @(posedge pclk);
        bus_ssync_in <= 1'b0;
      end
    end
  end
endmodule

//--- tb/test_peripheral_bus_slave_and_interrupt.sv
// self-checking bench for the peripheral bus slave with its interrupt masters
// assumes the design package and register header are compiled first
`timescale 1ns/10ps
`include "periph_bus_regs.svh"

module test_peripheral_bus_slave_and_interrupt;
  localparam int NOPS = 11;
  // address straps 10'h005: bits 3 and 5 must be zero
  localparam logic [17:0] BASE = 18'h3ffd0;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] bus_addr;
  periph_bus_pkg::cycle_t bus_cycle;
  logic bus_msync, bus_ssync_in, bus_ssync_out, bus_grant_in, bus_free, bus_request;
  logic [15:0] bus_data_in, bus_data_out, device_data_in, data_word, command_word, rd16;
  logic [2:0] bus_request_level, g;
  logic bus_intr, vector_accepted, out_high, out_low, in_gate;
  logic [1:0] bus_owner;
  logic [3:0] reg_select, sel;
  logic fault_flag, finish_flag, busy_flag, err, ack, soe_n, doe_n;
  logic [4:0] ans_delay;
  int checks = 0;
  int mismatches = 0;
  int hits;
  logic [2:0] op_off [NOPS] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h2, 3'h6, 3'h6, 3'h4, 3'h4, 3'h0, 3'h0};
  logic [1:0] op_cyc [NOPS] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
  logic [15:0] op_wd [NOPS] = '{16'h1234, 16'hab00, 16'h00cd, 16'h0, 16'h0, 16'h5a5a, 16'h0,
                                16'hffff, 16'h0, 16'hffff, 16'h0};
  logic [3:0] op_sel [NOPS] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 4'h1};
  logic [2:0] op_g [NOPS] = '{3'h6, 3'h4, 3'h2, 3'h1, 3'h1, 3'h6, 3'h1, 3'h6, 3'h1, 3'h6, 3'h1};
  logic [15:0] op_rd [NOPS] = '{16'h0, 16'h0, 16'h0, 16'habcd, 16'habcd, 16'h0, 16'h0, 16'h0,
                                16'hc3e1, 16'h0, 16'h4840};
  logic [17:0] bad [4] = '{18'h3dfd2, 18'h1ffd2, 18'h3ffd8, 18'h3ffc2};

  always #5 pclk = ~pclk;

  periph_bus_slave #(.REQ_LEVEL(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bus_addr(bus_addr), .bus_cycle(bus_cycle), .bus_msync(bus_msync),
    .bus_ssync_in(bus_ssync_in), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe_n(doe_n), .bus_ssync_out(bus_ssync_out), .bus_ssync_oe_n(soe_n),
    .bus_grant_in(bus_grant_in), .bus_grant_out(), .bus_free(bus_free),
    .bus_request(bus_request), .bus_request_level(bus_request_level), .bus_intr(bus_intr),
    .bus_owner(bus_owner), .vector_accepted(vector_accepted), .reg_select(reg_select),
    .out_high(out_high), .out_low(out_low), .in_gate(in_gate), .fault_flag(fault_flag),
    .finish_flag(finish_flag), .busy_flag(busy_flag), .device_data_in(device_data_in),
    .data_word(data_word), .command_word(command_word)
  );

  bus_processor_model u_proc (
    .pclk(pclk), .presetn(presetn), .ans_delay(ans_delay), .bus_request(bus_request),
    .bus_owner(bus_owner), .bus_intr(bus_intr), .vector_accepted(vector_accepted),
    .bus_grant_in(bus_grant_in), .bus_free(bus_free), .bus_ssync_in(bus_ssync_in)
  );

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one master cycle; a missing answer is reported through k
  task automatic bus_xfer(input logic [17:0] a, input periph_bus_pkg::cycle_t c,
                          input logic [15:0] wd, output logic k, output logic [15:0] d,
                          output logic [3:0] s, output logic [2:0] gt);
    k = 1'b0;
    d = 16'h0;
    s = 4'h0;
    gt = 3'h0;
    @(posedge pclk);
    bus_addr <= a;
    bus_cycle <= c;
    bus_data_in <= wd;
    bus_msync <= 1'b1;
    for (int i = 0; i < 8 && !k; i++)
    begin
      @(posedge pclk);
      if (bus_ssync_out === 1'b1)
      begin
        k = (soe_n === 1'b0);
        d = (doe_n === 1'b0) ? bus_data_out : 16'hdead;
        s = reg_select;
        gt = {out_high, out_low, in_gate};
      end
    end
    bus_msync <= 1'b0;
    for (int i = 0; i < 8 && bus_ssync_out === 1'b1; i++)
      @(posedge pclk);
    bus_data_in <= ~wd;
    repeat (2) @(posedge pclk);
  endtask

  task automatic irq_expect(input logic [1:0] own, input logic [7:0] vec, input logic rdv);
    logic [31:0] st;
    logic e;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++)
    begin
      @(posedge pclk);
      seen = (bus_intr === 1'b1);
    end
    chk("intr raised", 32'h1, 32'(seen));
    chk("owner", 32'(own), 32'(bus_owner));
    chk("req level", 32'h4, 32'(bus_request_level));
    if (rdv)
    begin
      apb(1'b0, `BUS_STATUS_OFFSET, 32'h0, st, e);
      chk("vector", 32'(vec), 32'(st[31:24]));
    end
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++)
    begin
      @(posedge pclk);
      seen = (vector_accepted === 1'b1);
    end
    chk("accepted", 32'h1, 32'(seen));
    repeat (2) @(posedge pclk);
    chk("intr released", 32'h0, 32'(bus_intr));
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bus_addr = 18'h0;
    bus_cycle = periph_bus_pkg::CYC_IN;
    bus_msync = 1'b0;
    bus_data_in = 16'h0;
    fault_flag = 1'b0;
    finish_flag = 1'b0;
    busy_flag = 1'b1;
    device_data_in = 16'hc3e1;
    ans_delay = 5'd12;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `STRAP_CFG_OFFSET, 32'h0, rd, err);
    chk("strap reset", 32'h0017_0000, rd);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, `STRAP_CFG_OFFSET, 32'h0017_0005, rd, err);
    apb(1'b0, `STRAP_CFG_OFFSET, 32'h0, rd, err);
    chk("strap cfg", 32'h0017_0005, rd);
    for (int i = 0; i < NOPS; i++)
    begin
      bus_xfer(BASE | 18'(op_off[i]), periph_bus_pkg::cycle_t'(op_cyc[i]), op_wd[i], ack,
               rd16, sel, g);
      chk("ack", 32'h1, 32'(ack));
      chk("select", 32'(op_sel[i]), 32'(sel));
      chk("gates", 32'(op_g[i]), 32'(g));
      if (op_cyc[i] < 2'h2)
        chk("read data", 32'(op_rd[i]), 32'(rd16));
    end
    chk("data word", 32'h0000_abcd, 32'(data_word));
    chk("command word", 32'h0000_5a5a, 32'(command_word));
    for (int i = 0; i < 4; i++)
    begin
      bus_xfer(bad[i], periph_bus_pkg::CYC_IN, 16'h0, ack, rd16, sel, g);
      chk("stray ack", 32'h0, 32'(ack));
    end
    fault_flag <= 1'b1;
    irq_expect(2'b01, 8'h44, 1'b1);
    fault_flag <= 1'b0;
    bus_xfer(BASE, periph_bus_pkg::CYC_OUT, 16'h4000, ack, rd16, sel, g);
    finish_flag <= 1'b1;
    hits = 0;
    repeat (12)
    begin
      @(posedge pclk);
      if (bus_request !== 1'b0)
        hits++;
    end
    chk("gated request", 32'h0, 32'(hits));
    finish_flag <= 1'b0;
    apb(1'b1, `STRAP_CFG_OFFSET, 32'h001f_0005, rd, err);
    bus_xfer(BASE, periph_bus_pkg::CYC_OUT, 16'h4040, ack, rd16, sel, g);
    fault_flag <= 1'b1;
    finish_flag <= 1'b1;
    irq_expect(2'b01, 8'h04, 1'b1);
    irq_expect(2'b10, 8'h00, 1'b1);
    fault_flag <= 1'b0;
    finish_flag <= 1'b0;
    ans_delay <= 5'd1;
    @(posedge pclk);
    finish_flag <= 1'b1;
    irq_expect(2'b10, 8'h00, 1'b0);
    end_sim();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
endmodule
